/* File: rtl/chip_cfg_pkg.sv */
// shared constants of the chip configuration register bank
// assumes a single core clock domain; serial pins sampled as synchronous inputs
package chip_cfg_pkg;

  localparam int ADDR_W = 15;  // serial command address width
  localparam int DATA_W = 8;   // register width

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CHIP_CONFIG    = 15'h0002;
  localparam logic [ADDR_W-1:0] OFS_DEVICE_TYPE    = 15'h0003;
  localparam logic [ADDR_W-1:0] OFS_IDENT_LOW      = 15'h0004;
  localparam logic [ADDR_W-1:0] OFS_IDENT_HIGH     = 15'h0005;
  localparam logic [ADDR_W-1:0] OFS_SPEED_GRADE    = 15'h0006;
  localparam logic [ADDR_W-1:0] OFS_CHANNEL_SELECT = 15'h0008;
  localparam logic [ADDR_W-1:0] OFS_SCRATCH        = 15'h000a;
  localparam logic [ADDR_W-1:0] OFS_PORT_REVISION  = 15'h000b;
  localparam logic [ADDR_W-1:0] OFS_MAKER_LOW      = 15'h000c;
  localparam logic [ADDR_W-1:0] OFS_MAKER_HIGH     = 15'h000d;
  localparam logic [ADDR_W-1:0] OFS_SHADOW_COPY    = 15'h000f;

  // channel power mode field codes
  localparam logic [1:0] PWR_NORMAL  = 2'h0;
  localparam logic [1:0] PWR_STANDBY = 2'h2;
  localparam logic [1:0] PWR_DOWN    = 2'h3;

  // field positions
  localparam int CHAN_A_BIT    = 0;
  localparam int CHAN_B_BIT    = 1;
  localparam int COPY_BIT      = 0;
  localparam int GRADE_LSB     = 4;

  // values after reset
  localparam logic [1:0]        RST_POWER_MODE = 2'h0;
  localparam logic [1:0]        RST_CHAN_SEL   = 2'h3;
  localparam logic [DATA_W-1:0] RST_SCRATCH    = 8'h00;

  // cycles the shadow-to-active copy takes before the strobe clears
  localparam int                TRANSFER_CYCLES = 4;
  localparam logic [2:0]        COPY_LAST       = 3'(TRANSFER_CYCLES - 1);

  // serial command framing
  localparam logic [4:0] HDR_BITS   = 5'h10;  // r/w flag plus address
  localparam logic [4:0] FRAME_LAST = 5'h17;  // last bit of a data byte

endpackage

/* File: rtl/reg_access_if.sv */
// register access carrier between the serial port front end and the register bank
// assumes both ends run on core_clk
`timescale 1ns/10ps
interface reg_access_if;
  import chip_cfg_pkg::*;

  logic              wrStb;   // one-cycle write pulse
  logic              rdStb;   // one-cycle read request pulse
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wrData;
  logic [DATA_W-1:0] rdData;  // held until the next read request

  modport port (output wrStb, output rdStb, output addr, output wrData, input rdData);
  modport regs (input wrStb, input rdStb, input addr, input wrData, output rdData);
endinterface

/* File: rtl/serial_ctrl_port.sv */
// serial control port front end: 16-bit header, then streamed data bytes
// assumes sclk is far slower than core_clk and is sampled as an ordinary input
`timescale 1ns/10ps
module serial_ctrl_port
  import chip_cfg_pkg::*;
(
  input  wire logic    core_clk,
  input  wire logic    rst_b,
  input  wire logic    spiCs_b,
  input  wire logic    spiSclk,
  input  wire logic    spiSdi,
  output logic         spiSdo,
  output logic         spiSdoEn,
  reg_access_if.port   bus
);
  import chip_cfg_pkg::*;

  typedef struct packed {
    logic              sclkQ;
    logic [4:0]        bitCnt;
    logic              isRead;
    logic [15:0]       shift;
    logic [ADDR_W-1:0] addr;
    logic              wrStb;
    logic              rdStb;
    logic              sdo;
    logic              sdoEn;
  } port_state_s;

  port_state_s st;
  port_state_s next_st;
  logic        rise;
  logic        fall;
  logic [2:0]  dataBit;

  // frame decode: header bits then bytes, address walks upward
  always_comb begin
    next_st = st;
    rise = spiSclk && !st.sclkQ;
    fall = !spiSclk && st.sclkQ;
    dataBit = 3'(st.bitCnt - HDR_BITS);
    next_st.sclkQ = spiSclk;
    next_st.wrStb = 1'b0;
    next_st.rdStb = 1'b0;
    if (spiCs_b) begin
      next_st.bitCnt = 5'h00;
      next_st.sdoEn = 1'b0;
    end else if (rise) begin
      next_st.shift = {st.shift[14:0], spiSdi};
      next_st.bitCnt = (st.bitCnt == FRAME_LAST) ? HDR_BITS : 5'(st.bitCnt + 5'h01);
      if (st.bitCnt == HDR_BITS - 5'h01) begin
        next_st.isRead = st.shift[14];
        next_st.addr = {st.shift[13:0], spiSdi};
        next_st.rdStb = st.shift[14];
      end else if (st.bitCnt == FRAME_LAST) begin
        next_st.addr = ADDR_W'(st.addr + 1'b1);
        next_st.wrStb = !st.isRead;
        next_st.rdStb = st.isRead;
      end
    end else if (fall && st.isRead && st.bitCnt >= HDR_BITS) begin
      next_st.sdoEn = 1'b1;
      next_st.sdo = bus.rdData[3'h7 - dataBit];
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // write data is the byte just shifted; address of a write is the one before the step
  assign bus.wrStb  = st.wrStb;
  assign bus.rdStb  = st.rdStb;
  assign bus.addr   = st.wrStb ? ADDR_W'(st.addr - 1'b1) : st.addr;
  assign bus.wrData = st.shift[7:0];
  assign spiSdo     = st.sdo;
  assign spiSdoEn   = st.sdoEn;

endmodule

/* File: rtl/converter_chip_config_regs.sv */
// chip-level configuration and identification register bank with serial control port
// assumes one core clock; datapath and link honour the enables and copy pulses driven here
`timescale 1ns/10ps

module converter_chip_config_regs
  import chip_cfg_pkg::*;
#(
  parameter logic [7:0] DEVICE_TYPE   = 8'h5a,  // arbitrary value
  parameter logic [7:0] IDENT_LOW     = 8'h11,  // arbitrary value
  parameter logic [7:0] IDENT_HIGH    = 8'h22,  // arbitrary value
  parameter logic [3:0] SPEED_GRADE   = 4'h0,
  parameter logic [7:0] PORT_REVISION = 8'h33,  // arbitrary value
  parameter logic [7:0] MAKER_LOW     = 8'h44,  // arbitrary value
  parameter logic [7:0] MAKER_HIGH    = 8'h55   // arbitrary value
) (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       spiCs_b,
  input  wire logic       spiSclk,
  input  wire logic       spiSdi,
  output logic            spiSdo,
  output logic            spiSdoEn,
  input  wire logic       mixerPhaseSyncMode,
  output logic            datapathClkEn,
  output logic            datapathRst_b,
  output logic            linkEn,
  output logic [1:0]      coreSelect,
  output logic            mixerPhaseCopy,
  output logic            programmableFilterCopy,
  output logic            shadowCopy
);
  import chip_cfg_pkg::*;

  typedef struct packed {
    logic [1:0]        powerMode;
    logic [1:0]        chanSel;
    logic [DATA_W-1:0] scratch;
    logic              copyBusy;
    logic [2:0]        copyCnt;
    logic [DATA_W-1:0] rdData;
    logic              dpClkEn;
    logic              dpRst_b;
    logic              linkOn;
    logic              phaseCopy;
    logic              filterCopy;
    logic              syncCopy;
  } cfg_state_s;

  cfg_state_s   st;
  cfg_state_s   next_st;
  logic         copyStart;
  reg_access_if bus ();

  // serial front end
  serial_ctrl_port u_port (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .spiCs_b  (spiCs_b),
    .spiSclk  (spiSclk),
    .spiSdi   (spiSdi),
    .spiSdo   (spiSdo),
    .spiSdoEn (spiSdoEn),
    .bus      (bus)
  );

  // read decode; reserved bits and unmapped addresses read zero
  function automatic logic [DATA_W-1:0] readByte(input logic [ADDR_W-1:0] a, input cfg_state_s s);
    logic [DATA_W-1:0] v;
    v = '0;
    unique case (a)
      OFS_CHIP_CONFIG:    v = {6'h00, s.powerMode};
      OFS_DEVICE_TYPE:    v = DEVICE_TYPE;
      OFS_IDENT_LOW:      v = IDENT_LOW;
      OFS_IDENT_HIGH:     v = IDENT_HIGH;
      OFS_SPEED_GRADE:    v = {SPEED_GRADE, 4'h0};
      OFS_CHANNEL_SELECT: v = {6'h00, s.chanSel};
      OFS_SCRATCH:        v = s.scratch;
      OFS_PORT_REVISION:  v = PORT_REVISION;
      OFS_MAKER_LOW:      v = MAKER_LOW;
      OFS_MAKER_HIGH:     v = MAKER_HIGH;
      OFS_SHADOW_COPY:    v = {7'h00, s.copyBusy};
      default:            v = '0;
    endcase
    return v;
  endfunction

  // a write of one to the strobe starts or restarts the copy
  assign copyStart = bus.wrStb && bus.addr == OFS_SHADOW_COPY && bus.wrData[COPY_BIT];

  // register writes, copy sequencing and derived controls
  always_comb begin
    next_st = st;
    if (bus.wrStb) begin
      unique case (bus.addr)
        OFS_CHIP_CONFIG:    next_st.powerMode = bus.wrData[1:0];
        OFS_CHANNEL_SELECT: next_st.chanSel = bus.wrData[1:0];
        OFS_SCRATCH:        next_st.scratch = bus.wrData;
        default:            next_st.scratch = st.scratch;
      endcase
    end
    if (bus.rdStb) begin
      next_st.rdData = readByte(bus.addr, st);
    end
    // copy counter; a fresh start wins over the completing clear
    if (copyStart) begin
      next_st.copyBusy = 1'b1;
      next_st.copyCnt = 3'h0;
    end else if (st.copyBusy) begin
      next_st.copyCnt = 3'(st.copyCnt + 3'h1);
      if (st.copyCnt == COPY_LAST) begin
        next_st.copyBusy = 1'b0;
      end
    end
    next_st.syncCopy = copyStart;
    next_st.filterCopy = copyStart;
    next_st.phaseCopy = copyStart && mixerPhaseSyncMode;
    // power mode decode; undocumented code 01 runs as normal
    next_st.dpClkEn = !(next_st.powerMode == PWR_STANDBY || next_st.powerMode == PWR_DOWN);
    next_st.dpRst_b = next_st.powerMode != PWR_DOWN;
    next_st.linkOn = next_st.powerMode != PWR_DOWN;
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.powerMode <= RST_POWER_MODE;
      st.chanSel <= RST_CHAN_SEL;
      st.scratch <= RST_SCRATCH;
      st.dpClkEn <= 1'b1;
      st.dpRst_b <= 1'b1;
      st.linkOn <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign bus.rdData             = st.rdData;
  assign datapathClkEn          = st.dpClkEn;
  assign datapathRst_b          = st.dpRst_b;
  assign linkEn                 = st.linkOn;
  assign coreSelect             = st.chanSel;
  assign mixerPhaseCopy         = st.phaseCopy;
  assign programmableFilterCopy = st.filterCopy;
  assign shadowCopy             = st.syncCopy;

  // power mode effects
  a_standby_clocks: assert property (@(posedge core_clk) disable iff (!rst_b)
    st.powerMode == PWR_STANDBY |-> !datapathClkEn && linkEn && datapathRst_b)
    else $error("standby does not gate clocks with link running");
  a_powerdown_all: assert property (@(posedge core_clk) disable iff (!rst_b)
    st.powerMode == PWR_DOWN |-> !datapathClkEn && !datapathRst_b && !linkEn)
    else $error("power-down does not stop datapath and link");
  a_normal_running: assert property (@(posedge core_clk) disable iff (!rst_b)
    st.powerMode == PWR_NORMAL |-> datapathClkEn && datapathRst_b && linkEn)
    else $error("normal mode does not run datapath");

  // channel selection follows the written bits
  a_core_b_select: assert property (@(posedge core_clk) disable iff (!rst_b)
    bus.wrStb && bus.addr == OFS_CHANNEL_SELECT |=> coreSelect[CHAN_B_BIT] == $past(bus.wrData[CHAN_B_BIT]))
    else $error("core B select not updated");
  a_core_a_select: assert property (@(posedge core_clk) disable iff (!rst_b)
    bus.wrStb && bus.addr == OFS_CHANNEL_SELECT |=> coreSelect[CHAN_A_BIT] == $past(bus.wrData[CHAN_A_BIT]))
    else $error("core A select not updated");

  // scratch byte stores the written byte and leaves the other settings alone
  a_scratch_store: assert property (@(posedge core_clk) disable iff (!rst_b)
    bus.wrStb && bus.addr == OFS_SCRATCH |=> st.scratch == $past(bus.wrData))
    else $error("scratch does not hold the written byte");
  a_scratch_isolated: assert property (@(posedge core_clk) disable iff (!rst_b)
    bus.wrStb && bus.addr == OFS_SCRATCH |=> $stable(st.powerMode) && $stable(st.chanSel))
    else $error("scratch write changed another setting");

  // copy pulses
  a_phase_gated: assert property (@(posedge core_clk) disable iff (!rst_b)
    copyStart |=> mixerPhaseCopy == $past(mixerPhaseSyncMode))
    else $error("mixer phase copy not gated by sync mode");
  a_filter_move: assert property (@(posedge core_clk) disable iff (!rst_b)
    copyStart |=> programmableFilterCopy && st.copyBusy)
    else $error("filter copy pulse missing");
  a_sync_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
    shadowCopy |-> $past(copyStart) && !$past(shadowCopy))
    else $error("shadow copy pulse without strobe write");
  a_no_stray_copy: assert property (@(posedge core_clk) disable iff (!rst_b)
    !copyStart |=> !shadowCopy && !programmableFilterCopy && !mixerPhaseCopy)
    else $error("copy pulse without strobe write");

  // strobe self-clear timing
  a_strobe_clears: assert property (@(posedge core_clk) disable iff (!rst_b)
    copyStart ##1 (!copyStart)[*4] |-> st.copyBusy ##1 !st.copyBusy)
    else $error("strobe does not clear after copy");
  a_strobe_readback: assert property (@(posedge core_clk) disable iff (!rst_b)
    bus.rdStb && bus.addr == OFS_SHADOW_COPY |=> bus.rdData == {7'h00, $past(st.copyBusy)})
    else $error("strobe read does not show copy progress");

  // identification reads return the fixed value
  a_ident_fixed: assert property (@(posedge core_clk) disable iff (!rst_b)
    bus.rdStb && bus.addr == OFS_IDENT_LOW |=> bus.rdData == IDENT_LOW)
    else $error("identification register altered");
  a_type_fixed: assert property (@(posedge core_clk) disable iff (!rst_b)
    bus.rdStb && bus.addr == OFS_DEVICE_TYPE |=> bus.rdData == DEVICE_TYPE)
    else $error("device type register altered");
  a_maker_fixed: assert property (@(posedge core_clk) disable iff (!rst_b)
    bus.rdStb && bus.addr == OFS_MAKER_HIGH |=> bus.rdData == MAKER_HIGH)
    else $error("maker register altered");
  a_revision_fixed: assert property (@(posedge core_clk) disable iff (!rst_b)
    bus.rdStb && bus.addr == OFS_PORT_REVISION |=> bus.rdData == PORT_REVISION)
    else $error("port revision register altered");

endmodule

/* File: verification/host_model.sv */
// host model: serial control port master sending a 16-bit header and one byte
// assumes core_clk from the bench; sclk half period is 4 core cycles, idle low
`timescale 1ns/10ps
module host_model (
  input  wire logic core_clk,
  output logic      spiCs_b,
  output logic      spiSclk,
  output logic      spiSdi,
  input  wire logic spiSdo,
  input  wire logic spiSdoEn
);
  // idle lines from time zero
  initial begin
    spiCs_b = 1'b1;
    spiSclk = 1'b0;
    spiSdi  = 1'b0;
  end

  // one frame msb first: read flag, address, data byte; read data taken before each rise
  task automatic frame(input logic rd, input logic [14:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [23:0] w;
    w = {rd, a, d};
    q = 8'h00;
    @(negedge core_clk) spiCs_b = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(negedge core_clk) spiSdi = w[i];
      repeat (3) @(negedge core_clk);
      if (i < 8) q[i] = spiSdoEn ? spiSdo : ~spiSdo;  // undriven line reads inverted
      spiSclk = 1'b1;
      repeat (4) @(negedge core_clk);
      spiSclk = 1'b0;
    end
    @(negedge core_clk) spiCs_b = 1'b1;
    spiSdi = ~spiSdi;  // released line shows no stale value
    repeat (4) @(negedge core_clk);
  endtask
endmodule

/* File: verification/tb_top.sv */
// self-checking bench of the configuration register bank
// assumes the host model as serial master; inputs change at the falling edge
`timescale 1ns/10ps
module tb_top;
  import chip_cfg_pkg::*;
  logic       core_clk, rst_b, spiCs_b, spiSclk, spiSdi, spiSdo, spiSdoEn, mixerPhaseSyncMode;
  logic       datapathClkEn, datapathRst_b, linkEn, mixerPhaseCopy, programmableFilterCopy, shadowCopy;
  logic [1:0] coreSelect;
  logic [7:0] q;
  int         bad_count, n_checks, nMix, nFilt, nShad;
  localparam logic [14:0] ROA [7] = '{OFS_DEVICE_TYPE, OFS_IDENT_LOW, OFS_IDENT_HIGH, OFS_SPEED_GRADE,
                                      OFS_PORT_REVISION, OFS_MAKER_LOW, OFS_MAKER_HIGH};
  localparam logic [7:0]  ROV [7] = '{8'h5a, 8'h11, 8'h22, 8'h00, 8'h33, 8'h44, 8'h55};

  converter_chip_config_regs i_dut (.core_clk(core_clk), .rst_b(rst_b), .spiCs_b(spiCs_b),
    .spiSclk(spiSclk), .spiSdi(spiSdi), .spiSdo(spiSdo), .spiSdoEn(spiSdoEn),
    .mixerPhaseSyncMode(mixerPhaseSyncMode), .datapathClkEn(datapathClkEn),
    .datapathRst_b(datapathRst_b), .linkEn(linkEn), .coreSelect(coreSelect),
    .mixerPhaseCopy(mixerPhaseCopy), .programmableFilterCopy(programmableFilterCopy),
    .shadowCopy(shadowCopy));
  host_model i_host (.core_clk(core_clk), .spiCs_b(spiCs_b), .spiSclk(spiSclk), .spiSdi(spiSdi),
    .spiSdo(spiSdo), .spiSdoEn(spiSdoEn));

  // clock generation
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // count copy pulses seen at the outputs
  always @(posedge core_clk) begin
    if (mixerPhaseCopy === 1'b1) nMix <= nMix + 1;
    if (programmableFilterCopy === 1'b1) nFilt <= nFilt + 1;
    if (shadowCopy === 1'b1) nShad <= nShad + 1;
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] x;
    i_host.frame(1'b0, a, d, x);
  endtask

  task automatic rd(input logic [14:0] a, output logic [7:0] d);
    i_host.frame(1'b1, a, 8'h00, d);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog sized well beyond the roughly 50 frames of the run
  initial begin
    #400000;
    bad_count++;
    print_verdict();
  end

  // test sequence
  initial begin
    logic [7:0] dv [3];
    logic       mv [3];
    logic [7:0] em [3];
    logic [7:0] eo [3];
    int         m0, f0, s0;
    rst_b = 1'b0;
    mixerPhaseSyncMode = 1'b0;
    {bad_count, n_checks} = '0;
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge core_clk);
    // reset state of outputs and registers
    chk("clk rst link", 8'h07, 8'({datapathClkEn, datapathRst_b, linkEn}));
    chk("coreSelect", 8'h03, 8'(coreSelect));
    rd(OFS_CHIP_CONFIG, q);
    chk("power mode", 8'h00, q);
    rd(OFS_CHANNEL_SELECT, q);
    chk("channel select", 8'h03, q);
    rd(OFS_SCRATCH, q);
    chk("scratch", 8'h00, q);
    rd(OFS_SHADOW_COPY, q);
    chk("strobe", 8'h00, q);
    // identification bytes hold their values through writes
    for (int i = 0; i < 7; i++) begin
      rd(ROA[i], q);
      chk("ident", ROV[i], q);
      wr(ROA[i], ~ROV[i]);
      rd(ROA[i], q);
      chk("ident after write", ROV[i], q);
    end
    wr(15'h0007, 8'hff);
    rd(15'h0007, q);
    chk("unmapped", 8'h00, q);
    $display("test reset and identification done");
    // scratch stores anything and touches nothing else
    wr(OFS_SCRATCH, 8'ha5);
    rd(OFS_SCRATCH, q);
    chk("scratch", 8'ha5, q);
    chk("coreSelect", 8'h03, 8'(coreSelect));
    chk("clk rst link", 8'h07, 8'({datapathClkEn, datapathRst_b, linkEn}));
    $display("test scratch done");
    // channel select bits, reserved bits read zero
    wr(OFS_CHANNEL_SELECT, 8'h01);
    chk("coreSelect", 8'h01, 8'(coreSelect));
    wr(OFS_CHANNEL_SELECT, 8'hfe);
    chk("coreSelect", 8'h02, 8'(coreSelect));
    rd(OFS_CHANNEL_SELECT, q);
    chk("channel select", 8'h02, q);
    wr(OFS_CHANNEL_SELECT, 8'h00);
    chk("coreSelect", 8'h00, 8'(coreSelect));
    wr(OFS_CHANNEL_SELECT, 8'h03);
    chk("coreSelect", 8'h03, 8'(coreSelect));
    $display("test channel select done");
    // power modes: standby, power-down, back to normal
    wr(OFS_CHIP_CONFIG, {6'h00, PWR_STANDBY});
    chk("standby", 8'h03, 8'({datapathClkEn, datapathRst_b, linkEn}));
    wr(OFS_CHIP_CONFIG, {6'h00, PWR_DOWN});
    chk("power-down", 8'h00, 8'({datapathClkEn, datapathRst_b, linkEn}));
    rd(OFS_CHIP_CONFIG, q);
    chk("power mode", 8'h03, q);
    wr(OFS_CHIP_CONFIG, 8'h01);
    chk("code 01 runs", 8'h07, 8'({datapathClkEn, datapathRst_b, linkEn}));
    wr(OFS_CHIP_CONFIG, {6'h00, PWR_STANDBY});
    wr(OFS_CHIP_CONFIG, {6'h00, PWR_NORMAL});
    chk("normal", 8'h07, 8'({datapathClkEn, datapathRst_b, linkEn}));
    $display("test power modes done");
    // strobe with sync mode off and on, then reserved bits only
    dv = '{8'h01, 8'h01, 8'hfe};
    mv = '{1'b0, 1'b1, 1'b1};
    em = '{8'h00, 8'h01, 8'h00};
    eo = '{8'h01, 8'h01, 8'h00};
    for (int i = 0; i < 3; i++) begin
      mixerPhaseSyncMode = mv[i];
      m0 = nMix;
      f0 = nFilt;
      s0 = nShad;
      wr(OFS_SHADOW_COPY, dv[i]);
      rd(OFS_SHADOW_COPY, q);
      chk("strobe cleared", 8'h00, q);
      chk("mixer copies", em[i], 8'(nMix - m0));
      chk("filter copies", eo[i], 8'(nFilt - f0));
      chk("shadow copies", eo[i], 8'(nShad - s0));
    end
    $display("test transfer strobe done");
    print_verdict();
  end
endmodule
